// [rtl/ppd_regs.svh]
`ifndef PPD_REGS_SVH
`define PPD_REGS_SVH

// Register offsets on the two address lines.
`define PPD_OFS_DATA      2'h0
`define PPD_OFS_STATUS    2'h1
`define PPD_OFS_CONTROL   2'h2

// Status register fields.
`define PPD_ST_TIMEOUT    0
`define PPD_ST_RSVD       1
`define PPD_ST_IRQ        2
`define PPD_ST_FAULT      3
`define PPD_ST_SELECT     4
`define PPD_ST_PAPER      5
`define PPD_ST_ACK        6
`define PPD_ST_BUSY       7

// Control register fields.
`define PPD_CT_IRQ_EN     4
`define PPD_CT_DIR        5
`define PPD_CT_RESET      8'h00
`define PPD_CT_RD_ONES    8'hc0

// Timing.
`define PPD_CLK_PERIOD_NS 20
`define PPD_TIMEOUT_NS    10000
`define PPD_TIMEOUT_CYC   ((`PPD_TIMEOUT_NS + `PPD_CLK_PERIOD_NS - 1) / `PPD_CLK_PERIOD_NS)

// Data path buffer.
`define PPD_DATA_W        8
`define PPD_FIFO_DEPTH    4

`endif

// [rtl/ppd_pkg.sv]
package ppd_pkg;
  typedef logic [7:0] ppd_byte_t;
  typedef logic [1:0] ppd_addr_t;
endpackage : ppd_pkg

// [rtl/ppd_port.sv]
// Function
// - Address 0 data, 1 status, 2 control; address 3 leaves the bus undriven.
// - Mode-select bit 0 gives compatible mode, 1 gives extended mode.
// - Compatible mode, strap low: writes drive the data pins, reads return last write.
// - Compatible mode: direction pin caught on the first clock after reset chooses driving or pin readback.
// - Extended mode: writes always latched; pins driven only while direction bit 0.
// - Extended mode reads: latch when direction bit 0, pin levels when 1.
// - Eight-bit bidirectional data; extended mode direction from the direction bit alone.
// - Status is read-only; writes to it change nothing.
// - In EPP mode status bit 0 sets on a timeout of at least 10 us.
// - Timeout flag clears after status read and on EPP enable rising.
// - Outside EPP mode status bit 0 reads 1.
// - Status bit 1 always reads 1.
// - Status bit 2 reads 1 outside EPP in compatible mode or with control bit 4 low, and in EPP with config bit 4 low.
// - Status bit 2 latches low on acknowledge rising edge; status read sets it.
// - Status bit 3 follows the live fault input.
// - Status bit 4 follows the live printer-selected input.
// - Status bit 5 follows the live paper-out input.
// - Status bit 6 follows the live acknowledge input pulsed low by printer.
// - Status bit 7 is the inverse of the busy input.
// - Config bit 0 enables EPP operation; config bit 1 picks the EPP revision.
`include "ppd_regs.svh"

module ppd_fifo #(
  parameter int WIDTH = `PPD_DATA_W,
  parameter int DEPTH = `PPD_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // Fill side.
  input  wire logic             in_valid_i,
  output wire logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side.
  output wire logic             out_valid_o,
  input  wire logic             out_ready_i,
  output wire logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [AW:0]      count_r;

  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rptr_r];

  // The pointers wrap only for a power-of-two depth, which is all we use.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end else begin
      if (push) wptr_r <= wptr_r + 1'b1;
      if (pop) rptr_r <= rptr_r + 1'b1;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (push) mem_r[wptr_r] <= in_data_i;
  end

  a_fifo_no_over: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    count_r <= (AW+1)'(DEPTH)) else $error("FIFO count above depth.");
endmodule : ppd_fifo

module ppd_port
  import ppd_pkg::*;
(
  // Clock and reset.
  input  wire logic      clk_sys_i,
  input  wire logic      reset_i,
  // Host register port.
  input  wire ppd_addr_t addr_i,
  input  wire ppd_byte_t wdata_i,
  input  wire logic      rd_i,
  input  wire logic      wr_i,
  output wire logic      wr_ready_o,
  output wire ppd_byte_t rdata_o,
  output wire logic      rdata_oe_n_o,
  // Mode and configuration bits.
  input  wire logic      mode_select_bit_i,
  input  wire logic      epp_enable_i,
  input  wire logic      epp_rev_i,
  input  wire logic      epp_irq_level_i,
  output wire logic      epp_rev_o,
  // EPP cycle in progress, from the transfer sequencer.
  input  wire logic      epp_cycle_busy_i,
  // Direction pin.
  input  wire logic      direction_pin_i,
  // Data pins.
  input  wire ppd_byte_t port_data_pins_i,
  output wire ppd_byte_t port_data_pins_o,
  output wire logic      port_data_pins_oe_n_o,
  input  wire logic      port_hold_i,
  // Printer handshake inputs.
  input  wire logic      fault_n_i,
  input  wire logic      printer_selected_input_i,
  input  wire logic      paper_out_input_i,
  input  wire logic      ack_n_i,
  input  wire logic      busy_i,
  // Control register contents.
  output wire ppd_byte_t printer_control_o
);
  localparam int TO_CYC = `PPD_TIMEOUT_CYC;

  ppd_byte_t  out_latch_r;
  ppd_byte_t  control_r;
  ppd_byte_t  rdata_r;
  logic       rdata_oe_n_r;
  logic       dir_pin_r;
  logic       dir_caught_r;
  logic       irq_status_r;
  logic       timeout_r;
  logic       ack_prev_r;
  logic       epp_en_prev_r;
  logic [9:0] to_cnt_r;

  // Decoding of the host access.
  wire sel_data   = (addr_i == `PPD_OFS_DATA);
  wire sel_status = (addr_i == `PPD_OFS_STATUS);
  wire sel_ctrl   = (addr_i == `PPD_OFS_CONTROL);
  wire sel_any    = sel_data || sel_status || sel_ctrl;
  wire wr_data    = wr_i && sel_data;
  wire wr_ctrl    = wr_i && sel_ctrl;
  wire rd_status  = rd_i && sel_status;

  wire extended   = mode_select_bit_i;
  wire dir_bit    = control_r[`PPD_CT_DIR];
  // Compatible mode uses the strap, extended mode the direction bit.
  wire dir_in     = extended ? dir_bit : dir_pin_r;

  // Data register writes pass through a small buffer so that a slow
  // printer side can hold the latch while the host keeps writing.
  wire       fifo_valid;
  ppd_byte_t fifo_data;
  ppd_fifo #(
    .WIDTH (`PPD_DATA_W),
    .DEPTH (`PPD_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (wr_data),
    .in_ready_o  (wr_ready_o),
    .in_data_i   (wdata_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (!port_hold_i),
    .out_data_o  (fifo_data)
  );
  wire latch_load = fifo_valid && !port_hold_i;

  // Interrupt-status flag is live only in these modes.
  wire irq_active = epp_enable_i ? epp_irq_level_i
                  : (extended && control_r[`PPD_CT_IRQ_EN]);
  wire ack_rise   = !ack_prev_r && ack_n_i;
  wire epp_rise   = epp_enable_i && !epp_en_prev_r;
  wire to_hit     = epp_enable_i && (to_cnt_r == 10'(TO_CYC - 1));

  // Status image.
  ppd_byte_t status_img;
  assign status_img[`PPD_ST_TIMEOUT] = epp_enable_i ? timeout_r : 1'b1;
  assign status_img[`PPD_ST_RSVD]    = 1'b1;
  assign status_img[`PPD_ST_IRQ]     = irq_active ? irq_status_r : 1'b1;
  assign status_img[`PPD_ST_FAULT]   = fault_n_i;
  assign status_img[`PPD_ST_SELECT]  = printer_selected_input_i;
  assign status_img[`PPD_ST_PAPER]   = paper_out_input_i;
  assign status_img[`PPD_ST_ACK]     = ack_n_i;
  assign status_img[`PPD_ST_BUSY]    = !busy_i;

  wire ppd_byte_t data_img = dir_in ? port_data_pins_i : out_latch_r;
  wire ppd_byte_t ctrl_img = control_r | `PPD_CT_RD_ONES;
  wire ppd_byte_t read_mux = sel_data   ? data_img
                           : sel_status ? status_img
                           : ctrl_img;

  assign rdata_o               = rdata_r;
  assign rdata_oe_n_o          = rdata_oe_n_r;
  assign port_data_pins_o      = out_latch_r;
  assign port_data_pins_oe_n_o = dir_in;
  assign printer_control_o     = control_r;
  assign epp_rev_o             = epp_enable_i && epp_rev_i;

  // Read data is captured at the strobe and held until the next one.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r      <= '0;
      rdata_oe_n_r <= 1'b1;
    end else if (rd_i) begin
      rdata_r      <= read_mux;
      rdata_oe_n_r <= !sel_any;
    end else begin
      rdata_oe_n_r <= 1'b1;
    end
  end

  // The latch is loaded in every mode; only the pin enable differs.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) out_latch_r <= '0;
    else if (latch_load) out_latch_r <= fifo_data;
  end

  // Status writes fall through: no branch updates any state for them.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) control_r <= `PPD_CT_RESET;
    else if (wr_ctrl) control_r <= wdata_i;
  end

  // The strap is caught by the first clock after release, never by reset.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      dir_pin_r    <= 1'b0;
      dir_caught_r <= 1'b0;
    end else if (!dir_caught_r) begin
      dir_pin_r    <= direction_pin_i;
      dir_caught_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ack_prev_r    <= 1'b1;
      epp_en_prev_r <= 1'b0;
    end else begin
      ack_prev_r    <= ack_n_i;
      epp_en_prev_r <= epp_enable_i;
    end
  end

  // A new acknowledge edge wins over a status read in the same cycle.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) irq_status_r <= 1'b1;
    else if (irq_active && ack_rise) irq_status_r <= 1'b0;
    else if (rd_status || !irq_active) irq_status_r <= 1'b1;
  end

  // Counts consecutive busy cycles of an EPP cycle.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) to_cnt_r <= '0;
    else if (!epp_enable_i || !epp_cycle_busy_i) to_cnt_r <= '0;
    else if (!to_hit) to_cnt_r <= to_cnt_r + 10'h001;
  end

  // A timeout arriving with a clearing event is kept.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) timeout_r <= 1'b0;
    else if (to_hit && epp_cycle_busy_i) timeout_r <= 1'b1;
    else if (rd_status || epp_rise) timeout_r <= 1'b0;
  end

  a_addr3_float: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_i && addr_i == 2'h3 |=> rdata_oe_n_o)
    else $error("Address 3 read drove the bus.");

  a_oe_one_cycle: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    !rd_i |=> rdata_oe_n_o)
    else $error("Read bus enabled without a read.");

  a_ctrl_ones: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_i && addr_i == 2'h2 |=> rdata_o[7:6] == 2'h3)
    else $error("Control read reserved bits not one.");

  a_compat_drive: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    dir_caught_r && !mode_select_bit_i && !dir_pin_r
    |-> !port_data_pins_oe_n_o)
    else $error("Compatible output mode not driving pins.");

  a_strap_stable: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    dir_caught_r |=> $stable(dir_pin_r))
    else $error("Direction strap changed after capture.");

  a_strap_pin_read: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_i && addr_i == 2'h0 && !mode_select_bit_i && dir_pin_r
    |=> rdata_o == $past(port_data_pins_i))
    else $error("Strapped input read did not return pins.");

  a_ext_dir_float: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    mode_select_bit_i && control_r[`PPD_CT_DIR] |-> port_data_pins_oe_n_o)
    else $error("Pins driven in extended input direction.");

  a_ext_pin_read: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_i && addr_i == 2'h0 && mode_select_bit_i && control_r[`PPD_CT_DIR]
    |=> rdata_o == $past(port_data_pins_i))
    else $error("Extended input read did not return pins.");

  a_ext_latch_read: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_i && addr_i == 2'h0 && mode_select_bit_i && !control_r[`PPD_CT_DIR]
    |=> rdata_o == $past(out_latch_r))
    else $error("Extended output read did not return latch.");

  // A buffered data write may drain in the same cycle, so exclude that case.
  a_status_wr_nop: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    wr_i && addr_i == 2'h1 && !latch_load
    |=> $stable(control_r) && $stable(out_latch_r))
    else $error("Status write changed state.");

  a_timeout_set: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    $rose(timeout_r) |-> $past(to_hit))
    else $error("Timeout flag set before its limit.");

  a_timeout_clear: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_status && !(to_hit && epp_cycle_busy_i) |=> !timeout_r)
    else $error("Timeout flag not cleared by status read.");

  a_timeout_epp_clr: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    epp_rise && !(to_hit && epp_cycle_busy_i) |=> !timeout_r)
    else $error("Timeout flag not cleared by EPP enable.");

  a_bit0_non_epp: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_i && addr_i == 2'h1 && !epp_enable_i |=> rdata_o[0])
    else $error("Status bit 0 not one outside EPP.");

  a_irq_quiet: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_status && !irq_active |=> rdata_o[`PPD_ST_IRQ])
    else $error("Inactive interrupt status not one.");

  a_irq_latch: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    irq_active && ack_rise |=> !irq_status_r)
    else $error("Acknowledge edge did not latch status low.");

  a_irq_read_set: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_status && !(irq_active && ack_rise) |=> irq_status_r)
    else $error("Status read did not set interrupt status.");

  a_live_bits: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_status |=> rdata_o[4] == $past(printer_selected_input_i)
      && rdata_o[5] == $past(paper_out_input_i)
      && rdata_o[6] == $past(ack_n_i))
    else $error("Status printer lines wrong.");

  a_busy_inv: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    rd_i && addr_i == 2'h1 |=> rdata_o[7] == !$past(busy_i)
      && rdata_o[3] == $past(fault_n_i) && rdata_o[1])
    else $error("Status live bits wrong.");
endmodule : ppd_port

// [test/ppd_printer_model.sv]
// Printer end of the cable: status lines, an acknowledge pulse, data pins.
module ppd_printer_model
  import ppd_pkg::*;
(
  // Clock.
  input  wire logic       clk_sys_i,
  // Commands from the bench: {busy, paper out, selected, fault_n}.
  input  wire logic [3:0] lines_i,
  input  wire logic       ack_go_i,
  input  wire ppd_byte_t  drv_i,
  // Block side of the data pins.
  input  wire ppd_byte_t  pins_i,
  input  wire logic       pins_oe_n_i,
  // Printer outputs.
  output wire ppd_byte_t  level_o,
  output wire logic       fault_n_o,
  output wire logic       sel_o,
  output wire logic       paper_o,
  output wire logic       busy_o,
  output wire logic       ack_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ack_cnt_r = 2'h0;

  // The acknowledge is a short low pulse, never a held level.
  always_ff @(posedge clk_sys_i) begin
    if (ack_go_i) begin
      ack_cnt_r <= 2'h3;
    end else if (ack_cnt_r != 2'h0) begin
      ack_cnt_r <= ack_cnt_r - 2'h1;
    end
  end

  assign ack_n_o   = (ack_cnt_r == 2'h0);
  assign level_o   = pins_oe_n_i ? drv_i : pins_i;
  assign fault_n_o = lines_i[0];
  assign sel_o     = lines_i[1];
  assign paper_o   = lines_i[2];
  assign busy_o    = lines_i[3];
endmodule : ppd_printer_model

// [test/ppd_port_tb.sv]
module ppd_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ppd_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, rd = 0, wr = 0, mode = 0, ack_go = 0;
  logic epp_en = 0, epp_rev = 0, ebusy = 0, hold = 0, dpin = 0, oe, eirq = 0;
  logic [3:0] lines = 4'h5;
  ppd_addr_t addr = 2'h0;
  ppd_byte_t wdata = 8'h00, drv = 8'h5a, d, rdata, pins_o, lvl, ctl;
  wire logic wr_ready, rdata_oe_n, rev_o, oe_n, f_n, sel, pap, ack_n, bsy;
  int n_mismatch = 0;
  int checks_done = 0;

  ppd_port dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr),
    .wdata_i(wdata), .rd_i(rd), .wr_i(wr), .wr_ready_o(wr_ready),
    .rdata_o(rdata), .rdata_oe_n_o(rdata_oe_n),
    .mode_select_bit_i(mode), .epp_enable_i(epp_en), .epp_rev_i(epp_rev),
    .epp_irq_level_i(eirq), .epp_rev_o(rev_o),
    .epp_cycle_busy_i(ebusy), .direction_pin_i(dpin),
    .port_data_pins_i(lvl), .port_data_pins_o(pins_o),
    .port_data_pins_oe_n_o(oe_n), .port_hold_i(hold), .fault_n_i(f_n),
    .printer_selected_input_i(sel), .paper_out_input_i(pap),
    .ack_n_i(ack_n), .busy_i(bsy), .printer_control_o(ctl));

  ppd_printer_model prn (.clk_sys_i(clk_sys_i), .lines_i(lines),
    .ack_go_i(ack_go), .drv_i(drv), .pins_i(pins_o), .pins_oe_n_i(oe_n),
    .level_o(lvl), .fault_n_o(f_n), .sel_o(sel), .paper_o(pap),
    .busy_o(bsy), .ack_n_o(ack_n));

  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  function automatic ppd_byte_t stx(logic irq, logic to);
    stx = {~lines[3], 1'b1, lines[2], lines[1], lines[0], irq, 1'b1, to};
  endfunction : stx

  task automatic chk(ppd_byte_t got, ppd_byte_t exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_reg(ppd_addr_t a);
    @(posedge clk_sys_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1;
    d = rdata;
    oe = rdata_oe_n;
  endtask : rd_reg

  task automatic wr_reg(ppd_addr_t a, ppd_byte_t v);
    @(posedge clk_sys_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // Longest path is two timeout waits plus about 130 cycles of access.
  initial begin
    #(20 * 4000);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b1));
    chk({7'h0, oe}, 8'h00);
    @(posedge clk_sys_i) lines <= 4'ha;
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b1));
    wr_reg(2'h1, 8'h00);
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b1));
    rd_reg(2'h3);
    chk({7'h0, oe}, 8'h01);
    $display("test status done");
    wr_reg(2'h0, 8'ha5);
    repeat (3) @(posedge clk_sys_i);
    chk(pins_o, 8'ha5);
    chk({7'h0, oe_n}, 8'h00);
    rd_reg(2'h0);
    chk(d, 8'ha5);
    $display("test compatible done");
    @(posedge clk_sys_i) mode <= 1'b1;
    wr_reg(2'h2, 8'h20);
    wr_reg(2'h0, 8'h3c);
    repeat (3) @(posedge clk_sys_i);
    chk(pins_o, 8'h3c);
    chk({7'h0, oe_n}, 8'h01);
    rd_reg(2'h0);
    chk(d, 8'h5a);
    rd_reg(2'h2);
    chk(d, 8'he0);
    wr_reg(2'h2, 8'h00);
    @(posedge clk_sys_i);
    chk({7'h0, oe_n}, 8'h00);
    rd_reg(2'h0);
    chk(d, 8'h3c);
    $display("test extended done");
    wr_reg(2'h2, 8'h10);
    @(posedge clk_sys_i) ack_go <= 1'b1;
    @(posedge clk_sys_i) ack_go <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rd_reg(2'h1);
    chk(d, stx(1'b0, 1'b1));
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b1));
    @(posedge clk_sys_i) mode <= 1'b0;
    @(posedge clk_sys_i) ack_go <= 1'b1;
    @(posedge clk_sys_i) ack_go <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b1));
    $display("test interrupt flag done");
    @(posedge clk_sys_i) epp_en <= 1'b1;
    epp_rev <= 1'b1;
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b0));
    chk({7'h0, rev_o}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys_i) ebusy <= 1'b1;
      repeat (505) @(posedge clk_sys_i);
      ebusy <= 1'b0;
      if (k == 1) begin
        @(posedge clk_sys_i) epp_en <= 1'b0;
        @(posedge clk_sys_i) epp_en <= 1'b1;
      end
      rd_reg(2'h1);
      chk(d, stx(1'b1, (k == 0)));
    end
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b0));
    @(posedge clk_sys_i) eirq <= 1'b1;
    ack_go <= 1'b1;
    @(posedge clk_sys_i) ack_go <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rd_reg(2'h1);
    chk(d, stx(1'b0, 1'b0));
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b0));
    @(posedge clk_sys_i) eirq <= 1'b0;
    $display("test timeout done");
    @(posedge clk_sys_i) epp_en <= 1'b0;
    hold <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr_reg(2'h0, 8'(i + 1));
    end
    @(posedge clk_sys_i);
    chk({7'h0, wr_ready}, 8'h00);
    hold <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    chk({7'h0, wr_ready}, 8'h01);
    chk(pins_o, 8'h04);
    $display("test buffer done");
    // Second reset with the strap high: the port comes back in input mode.
    @(posedge clk_sys_i) reset_i <= 1'b1;
    dpin <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    chk(pins_o, 8'h00);
    chk(ctl, 8'h00);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk({7'h0, oe_n}, 8'h01);
    wr_reg(2'h0, 8'h96);
    repeat (3) @(posedge clk_sys_i);
    chk(pins_o, 8'h96);
    chk({7'h0, oe_n}, 8'h01);
    rd_reg(2'h0);
    chk(d, 8'h5a);
    rd_reg(2'h1);
    chk(d, stx(1'b1, 1'b1));
    $display("test strap done");
    tally_and_finish();
  end
endmodule : ppd_port_tb
